// ---- hdl/crate_ctl_pkg.sv ----
// constants shared by the crate control unit design
package crate_ctl_pkg;
    localparam int          ADDR_W          = 16;
    localparam int          DATA_W          = 8;
    localparam int          NUM_STATIONS    = 23;
    localparam int          BLOCK_BYTES     = 64;
    localparam int          HOST_W          = 16;
    localparam int          HADDR_W         = 16;
    // select region: a15..a10 all ones, a9..a5 choose the unit
    localparam logic [5:0]  SEL_REGION      = 6'h3F;
    localparam logic [4:0]  SEL_CTRL_UNIT   = 5'h18;
    // local register offsets on register_select_lines while the control unit is chosen
    localparam logic [4:0]  OFF_ATTN0       = 5'h00;
    localparam logic [4:0]  OFF_ATTN1       = 5'h01;
    localparam logic [4:0]  OFF_ATTN2       = 5'h02;
    localparam logic [4:0]  OFF_CTRL        = 5'h03;
    localparam logic [4:0]  OFF_STATUS      = 5'h04;
    localparam logic [4:0]  OFF_START_LO    = 5'h05;
    localparam logic [4:0]  OFF_START_HI    = 5'h06;
    localparam logic [4:0]  OFF_END_LO      = 5'h07;
    localparam logic [4:0]  OFF_END_HI      = 5'h08;
    localparam logic [4:0]  OFF_MOVER_GO    = 5'h09;
    localparam logic [4:0]  OFF_STAT_FIFO   = 5'h0A;
    localparam logic [4:0]  OFF_INSTR_FIFO  = 5'h0B;
    // control register fields
    localparam int          CTRL_GATE_BIT   = 7;
    localparam int          GO_DIR_BIT      = 0;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam logic [15:0] ADDR_RESET      = 16'h0000;
    localparam int          FIFO_DEPTH      = 4;
endpackage

// ---- hdl/byte_fifo.sv ----
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_r;
    logic [AW-1:0]    rd_r;
    logic [AW:0]      cnt_r;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;
    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rd_r];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ---- hdl/crate_controller.sv ----
// crate controller: station select, command lines, attention buffer, mover
//
// Contract
// - addresses 64512 to 65247 select a station
// - top six ones, a5..a9 pick one select
// - data, register_select_lines, strokes extend onto command lines
// - selected station devices answer cpu i/o
// - register buffers the 23 attention lines
// - attention buffer read as three bytes
// - one gated control, one status byte
// - mover holds software start and end address
// - mover steals cycles until end address or 64 bytes
// - mover toggles handshakes, one byte each
// - messages move in 64-byte blocks
// - two fifos: status out, instructions in
// - host words split to and from bytes
// - one station addressed at a time
`timescale 1ns/1ns
`default_nettype none
module crate_controller
    import crate_ctl_pkg::*;
#(
    parameter int NSTAT = crate_ctl_pkg::NUM_STATIONS,
    parameter int BLOCK = crate_ctl_pkg::BLOCK_BYTES
) (
    input  wire logic                              clk,
    input  wire logic                              reset_n,
    input  wire logic [crate_ctl_pkg::ADDR_W-1:0]  cpu_addr,
    input  wire logic [crate_ctl_pkg::DATA_W-1:0]  cpu_data_bits,
    input  wire logic                              cpu_io_wr,
    input  wire logic                              cpu_io_rd,
    output logic      [crate_ctl_pkg::DATA_W-1:0]  cpu_rd_data,
    output logic                                   cpu_mem_sel,
    output logic      [NSTAT-1:0]                  station_sel,
    output logic      [crate_ctl_pkg::DATA_W-1:0]  command_data_out,
    output logic                                   command_data_oe,
    input  wire logic [crate_ctl_pkg::DATA_W-1:0]  command_data_in,
    output logic      [4:0]                        register_select_lines,
    output logic                                   cmd_write,
    output logic                                   cmd_read,
    input  wire logic [NSTAT-1:0]                  attention_request,
    output logic      [crate_ctl_pkg::DATA_W-1:0]  host_ctrl_out,
    input  wire logic [crate_ctl_pkg::DATA_W-1:0]  host_status_in,
    output logic                                   block_handshake_one,
    input  wire logic                              block_handshake_two,
    input  wire logic [crate_ctl_pkg::DATA_W-1:0]  block_data_in,
    output logic      [crate_ctl_pkg::DATA_W-1:0]  block_data_out,
    output logic      [crate_ctl_pkg::HADDR_W-1:0] host_addr,
    output logic                                   host_req,
    output logic                                   host_wr,
    output logic      [crate_ctl_pkg::HOST_W-1:0]  host_wdata,
    input  wire logic [crate_ctl_pkg::HOST_W-1:0]  host_rdata,
    input  wire logic                              host_grant,
    input  wire logic [crate_ctl_pkg::HOST_W-1:0]  host_instr,
    input  wire logic                              host_instr_valid,
    output logic                                   host_instr_ready,
    output logic      [crate_ctl_pkg::HOST_W-1:0]  host_status,
    output logic                                   host_status_valid,
    input  wire logic                              host_status_ready,
    output logic                                   mover_busy
);
    import crate_ctl_pkg::*;

    // ----------------------------------------------------------------
    // station select
    // ----------------------------------------------------------------
    wire        in_region = (cpu_addr[15:10] == SEL_REGION);
    wire [4:0]  unit_code = cpu_addr[9:5];
    wire        sel_ctrl  = in_region && (unit_code == SEL_CTRL_UNIT);
    wire [4:0]  loc_off   = cpu_addr[4:0];
    assign cpu_mem_sel = !in_region;
    // codes 0..22 are stations; 23 and 25..31 select nothing
    genvar g;
    generate
        for (g = 0; g < NSTAT; g++) begin : g_sel
            assign station_sel[g] = in_region &&
                                    (unit_code == 5'(g));
        end
    endgenerate
    wire any_station = |station_sel;

    // ----------------------------------------------------------------
    // command line extension
    // ----------------------------------------------------------------
    // station devices answer only while selected; one code at a time
    assign command_data_out      = cpu_data_bits;
    assign command_data_oe       = any_station && cpu_io_wr;
    assign register_select_lines = loc_off;
    assign cmd_write             = any_station && cpu_io_wr;
    assign cmd_read              = any_station && cpu_io_rd;

    // ----------------------------------------------------------------
    // attention buffer: pins pass two flops
    // ----------------------------------------------------------------
    logic [NSTAT-1:0] attn_s1_r;
    logic [NSTAT-1:0] attn_s2_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            attn_s1_r <= '0;
            attn_s2_r <= '0;
        end else begin
            attn_s1_r <= attention_request;
            attn_s2_r <= attn_s1_r;
        end
    end
    wire [23:0] attention_line_buffer = 24'(attn_s2_r);

    logic [DATA_W-1:0] status_s1_r;
    logic [DATA_W-1:0] status_s2_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_s1_r <= '0;
            status_s2_r <= '0;
        end else begin
            status_s1_r <= host_status_in;
            status_s2_r <= status_s1_r;
        end
    end

    // ----------------------------------------------------------------
    // local registers
    // ----------------------------------------------------------------
    logic [7:0]         ctrl_r;
    logic [HADDR_W-1:0] start_r;
    logic [HADDR_W-1:0] end_r;
    logic               dir_r;
    wire loc_wr = sel_ctrl && cpu_io_wr;
    wire loc_rd = sel_ctrl && cpu_io_rd;
    wire go_wr  = loc_wr && (loc_off == OFF_MOVER_GO);
    // gated output: outputs float to zero while the gate bit is low
    assign host_ctrl_out = ctrl_r[CTRL_GATE_BIT] ? ctrl_r : '0;

    // ----------------------------------------------------------------
    // status and instruction fifos with word packing
    // ----------------------------------------------------------------
    logic [7:0]  stat_lo_r;
    logic        stat_have_r;
    wire         st_in_ready;
    wire         st_push = loc_wr && (loc_off == OFF_STAT_FIFO) &&
                           stat_have_r && st_in_ready;
    byte_fifo #(.WIDTH(HOST_W), .DEPTH(FIFO_DEPTH)) u_stat_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .in_data   ({cpu_data_bits, stat_lo_r}),
        .in_valid  (st_push),
        .in_ready  (st_in_ready),
        .out_data  (host_status),
        .out_valid (host_status_valid),
        .out_ready (host_status_ready)
    );
    wire [HOST_W-1:0] ins_word;
    wire              ins_valid;
    logic             ins_hi_r;
    wire ins_rd  = loc_rd && (loc_off == OFF_INSTR_FIFO) && ins_valid;
    wire ins_pop = ins_rd && ins_hi_r;
    byte_fifo #(.WIDTH(HOST_W), .DEPTH(FIFO_DEPTH)) u_instr_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .in_data   (host_instr),
        .in_valid  (host_instr_valid),
        .in_ready  (host_instr_ready),
        .out_data  (ins_word),
        .out_valid (ins_valid),
        .out_ready (ins_pop)
    );

    // ----------------------------------------------------------------
    // block mover
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        MV_IDLE, MV_FETCH, MV_SEND, MV_RECV, MV_STORE, MV_NEXT
    } mover_state_t;
    mover_state_t       mv_r;
    logic [HADDR_W-1:0] ptr_r;
    logic [HOST_W-1:0]  word_r;
    logic               half_r;
    logic [6:0]         bcnt_r;
    logic [1:0]         h2_s_r;
    // levels, not edges: a port answer that lands while the mover is
    // fetching or storing stays visible until the mover uses it
    wire hs_pending = h2_s_r[1] != block_handshake_one;
    wire last_word = (ptr_r == end_r);
    wire blk_full  = (bcnt_r == 7'(BLOCK));
    assign mover_busy = (mv_r != MV_IDLE);
    assign host_addr  = ptr_r;
    assign host_req   = (mv_r == MV_FETCH) || (mv_r == MV_STORE);
    assign host_wr    = (mv_r == MV_STORE);
    assign host_wdata = word_r;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            h2_s_r    <= '0;
        end else begin
            h2_s_r    <= {h2_s_r[0], block_handshake_two};
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mv_r                <= MV_IDLE;
            ptr_r               <= ADDR_RESET;
            word_r              <= '0;
            half_r              <= 1'b0;
            bcnt_r              <= '0;
            block_handshake_one <= 1'b0;
            block_data_out      <= '0;
        end else begin
            case (mv_r)
                MV_IDLE: begin
                    if (go_wr) begin
                        ptr_r  <= start_r;
                        half_r <= 1'b0;
                        bcnt_r <= '0;
                        // dir_r only takes the new direction at this edge
                        mv_r   <= cpu_data_bits[GO_DIR_BIT] ? MV_RECV
                                                            : MV_FETCH;
                    end
                end
                MV_FETCH: begin
                    if (host_grant) begin
                        word_r <= host_rdata;
                        mv_r   <= MV_SEND;
                    end
                end
                MV_SEND: begin
                    if (!hs_pending) begin
                        block_data_out <= half_r ? word_r[15:8]
                                                 : word_r[7:0];
                        block_handshake_one <= !block_handshake_one;
                        bcnt_r <= bcnt_r + 7'd1;
                        half_r <= !half_r;
                        if (half_r) begin
                            mv_r <= MV_NEXT;
                        end
                    end
                end
                MV_RECV: begin
                    if (hs_pending) begin
                        if (half_r) begin
                            word_r[15:8] <= block_data_in;
                            mv_r <= MV_STORE;
                        end else begin
                            word_r[7:0] <= block_data_in;
                        end
                        half_r <= !half_r;
                        bcnt_r <= bcnt_r + 7'd1;
                        block_handshake_one <= !block_handshake_one;
                    end
                end
                MV_STORE: begin
                    if (host_grant) begin
                        mv_r <= MV_NEXT;
                    end
                end
                MV_NEXT: begin
                    // a block ends at 64 bytes or at the end address
                    if (last_word || blk_full) begin
                        mv_r <= MV_IDLE;
                    end else begin
                        ptr_r <= ptr_r + 16'd1;
                        mv_r  <= dir_r ? MV_RECV : MV_FETCH;
                    end
                end
                default: mv_r <= MV_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r      <= CTRL_RESET;
            start_r     <= ADDR_RESET;
            end_r       <= ADDR_RESET;
            dir_r       <= 1'b0;
            stat_lo_r   <= '0;
            stat_have_r <= 1'b0;
            ins_hi_r    <= 1'b0;
        end else begin
            if (loc_wr) begin
                case (loc_off)
                    OFF_CTRL:     ctrl_r        <= cpu_data_bits;
                    OFF_START_LO: start_r[7:0]  <= cpu_data_bits;
                    OFF_START_HI: start_r[15:8] <= cpu_data_bits;
                    OFF_END_LO:   end_r[7:0]    <= cpu_data_bits;
                    OFF_END_HI:   end_r[15:8]   <= cpu_data_bits;
                    OFF_MOVER_GO: begin
                        if (!mover_busy) begin
                            dir_r <= cpu_data_bits[GO_DIR_BIT];
                        end
                    end
                    OFF_STAT_FIFO: begin
                        if (!stat_have_r) begin
                            stat_lo_r   <= cpu_data_bits;
                            stat_have_r <= 1'b1;
                        end else if (st_in_ready) begin
                            stat_have_r <= 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
            if (ins_rd) begin
                ins_hi_r <= !ins_hi_r;
            end
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (any_station) begin
            rd_mux = command_data_in;
        end else if (sel_ctrl) begin
            case (loc_off)
                OFF_ATTN0:      rd_mux = attention_line_buffer[7:0];
                OFF_ATTN1:      rd_mux = attention_line_buffer[15:8];
                OFF_ATTN2:      rd_mux = attention_line_buffer[23:16];
                OFF_CTRL:       rd_mux = ctrl_r;
                OFF_STATUS:     rd_mux = status_s2_r;
                OFF_START_LO:   rd_mux = start_r[7:0];
                OFF_START_HI:   rd_mux = start_r[15:8];
                OFF_END_LO:     rd_mux = end_r[7:0];
                OFF_END_HI:     rd_mux = end_r[15:8];
                OFF_MOVER_GO:   rd_mux = {7'h00, mover_busy};
                OFF_INSTR_FIFO: rd_mux = ins_hi_r ? ins_word[15:8]
                                                  : ins_word[7:0];
                default:        rd_mux = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cpu_rd_data <= '0;
        end else if (cpu_io_rd) begin
            cpu_rd_data <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_onehot_sel;
        @(posedge clk) disable iff (!reset_n)
        $countones(station_sel) <= 1;
    endproperty
    a_onehot_sel: assert property (p_onehot_sel)
        else $error("more than one station select");

    property p_region;
        @(posedge clk) disable iff (!reset_n)
        (cpu_addr > 16'd65511 || any_station) |-> !cpu_mem_sel;
    endproperty
    a_region: assert property (p_region)
        else $error("select region reached ordinary memory");

    property p_unused;
        @(posedge clk) disable iff (!reset_n)
        (in_region && unit_code > 5'd22) |-> !any_station;
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused code selected a station");

    property p_cmd_ext;
        @(posedge clk) disable iff (!reset_n)
        cmd_write |-> (command_data_out == cpu_data_bits &&
                       register_select_lines == cpu_addr[4:0]);
    endproperty
    a_cmd_ext: assert property (p_cmd_ext)
        else $error("command lines not tracking cpu");

    property p_attn;
        @(posedge clk) disable iff (!reset_n)
        ##2 attn_s2_r == $past(attention_request, 2);
    endproperty
    a_attn: assert property (p_attn)
        else $error("attention buffer lag wrong");

    property p_block;
        @(posedge clk) disable iff (!reset_n)
        bcnt_r <= 7'(BLOCK);
    endproperty
    a_block: assert property (p_block)
        else $error("block exceeded 64 bytes");

    property p_gate;
        @(posedge clk) disable iff (!reset_n)
        !ctrl_r[CTRL_GATE_BIT] |-> host_ctrl_out == 8'h00;
    endproperty
    a_gate: assert property (p_gate)
        else $error("control output not gated");

    sequence s_go;
        mv_r == MV_IDLE && go_wr;
    endsequence
    property p_start;
        @(posedge clk) disable iff (!reset_n)
        s_go |=> ptr_r == $past(start_r);
    endproperty
    a_start: assert property (p_start)
        else $error("mover did not load start address");

    property p_hs;
        @(posedge clk) disable iff (!reset_n)
        $changed(block_handshake_one) |-> bcnt_r == $past(bcnt_r) + 7'd1;
    endproperty
    a_hs: assert property (p_hs)
        else $error("handshake without byte count");
endmodule
`default_nettype wire

// ---- tb/host_port_model.sv ----
// host memory and port station stand-in for the crate controller bench
`timescale 1ns/1ns
`default_nettype none
module host_port_model (
    input  wire logic        clk,
    input  wire logic        port_sends,
    input  wire logic        host_req,
    input  wire logic        host_wr,
    input  wire logic [15:0] host_addr,
    input  wire logic [15:0] host_wdata,
    output logic      [15:0] host_rdata,
    output logic             host_grant,
    input  wire logic        block_handshake_one,
    output logic             block_handshake_two,
    output logic      [7:0]  block_data_in,
    input  wire logic [7:0]  block_data_out,
    input  wire logic        cmd_read,
    input  wire logic [4:0]  register_select_lines,
    output logic      [7:0]  command_data_in
);
    logic [7:0]  rx_mem [0:15];
    logic [15:0] wr_mem [0:3];
    int          rx_cnt = 0;
    int          tx_cnt = 0;
    int          wait_cnt = 0;
    initial {block_handshake_two, block_data_in} = 9'h0;
    // grant lags two cycles so the mover must hold its request
    assign host_grant = host_req && wait_cnt == 2;
    assign host_rdata = host_grant ? host_addr ^ 16'h5A3C : ~host_addr;
    // released bus shows the inverse, not the last value
    assign command_data_in = cmd_read ? {3'h5, register_select_lines}
                                      : {3'h2, ~register_select_lines};
    always @(posedge clk) begin
        wait_cnt <= (host_req && wait_cnt < 2) ? wait_cnt + 1 : 0;
        if (host_grant && host_wr) begin
            wr_mem[host_addr[1:0]] <= host_wdata;
        end
        // receiving: answer each byte by copying the mover's level
        if (!port_sends && block_handshake_one != block_handshake_two) begin
            rx_mem[rx_cnt[3:0]] <= block_data_out;
            rx_cnt <= rx_cnt + 1;
            block_handshake_two <= block_handshake_one;
        end
        // sending: offer the next byte once the mover has answered
        if (port_sends && block_handshake_one == block_handshake_two) begin
            block_data_in <= 8'hC0 + tx_cnt[7:0];
            tx_cnt <= tx_cnt + 1;
            block_handshake_two <= ~block_handshake_two;
        end
    end
endmodule
`default_nettype wire

// ---- tb/port_crate_control_unit_bench.sv ----
// self-checking bench for the crate controller
`timescale 1ns/1ns
`default_nettype none
module port_crate_control_unit_bench;
    import crate_ctl_pkg::*;
    localparam logic [15:0] CU = 16'hFF00;
    logic        clk, reset_n, cpu_io_wr, cpu_io_rd, cpu_mem_sel, port_sends;
    logic        command_data_oe, cmd_write, cmd_read, mover_busy;
    logic        block_handshake_one, block_handshake_two, host_grant;
    logic        host_req, host_wr, host_instr_valid, host_instr_ready;
    logic        host_status_valid, host_status_ready;
    logic [15:0] cpu_addr, host_addr, host_wdata, host_rdata;
    logic [15:0] host_instr, host_status;
    logic [7:0]  cpu_data_bits, cpu_rd_data, command_data_out;
    logic [7:0]  command_data_in, host_ctrl_out, host_status_in;
    logic [7:0]  block_data_in, block_data_out, d;
    logic [22:0] station_sel, attention_request;
    logic [4:0]  register_select_lines;
    int          mismatches = 0, total_checks = 0, cyc = 0, n;
    crate_controller i_crate_controller (.clk, .reset_n, .cpu_addr,
        .cpu_data_bits, .cpu_io_wr, .cpu_io_rd, .cpu_rd_data, .cpu_mem_sel,
        .station_sel, .command_data_out, .command_data_oe, .command_data_in,
        .register_select_lines, .cmd_write, .cmd_read, .attention_request,
        .host_ctrl_out, .host_status_in, .block_handshake_one,
        .block_handshake_two, .block_data_in, .block_data_out, .host_addr,
        .host_req, .host_wr, .host_wdata, .host_rdata, .host_grant,
        .host_instr, .host_instr_valid, .host_instr_ready, .host_status,
        .host_status_valid, .host_status_ready, .mover_busy);
    host_port_model i_host_port_model (.clk, .port_sends, .host_req,
        .host_wr, .host_addr, .host_wdata, .host_rdata, .host_grant,
        .block_handshake_one, .block_handshake_two, .block_data_in,
        .block_data_out, .cmd_read, .register_select_lines,
        .command_data_in);
    always #25 clk = ~clk;
    // a hang is cut short well past the longest expected run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(negedge clk) {cpu_addr, cpu_data_bits, cpu_io_wr} = {a, v, 1'b1};
        @(negedge clk) cpu_io_wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(negedge clk) {cpu_addr, cpu_io_rd} = {a, 1'b1};
        @(negedge clk) cpu_io_rd = 1'b0;
        v = cpu_rd_data;
    endtask
    task automatic t_select();
        for (int c = 0; c < 32; c++) begin
            @(negedge clk) cpu_addr = 16'hFC00 | 16'(c << 5);
            #1;
            chk("sel", (c < 23) ? 24'(1 << c) : 24'h0, 24'(station_sel));
            chk("memsel", 24'h0, 24'(cpu_mem_sel));
        end
        @(negedge clk) cpu_addr = 16'hFBFF;
        #1 chk("below", 24'h800000, {cpu_mem_sel, station_sel});
        @(negedge clk) cpu_addr = 16'hFFE8;
        #1 chk("above", 24'h0, {cpu_mem_sel, station_sel});
        $display("select test done");
    endtask
    task automatic t_station();
        @(negedge clk) {cpu_addr, cpu_data_bits, cpu_io_wr} = {16'hFCB3, 8'hA7, 1'b1};
        #1 chk("cmd_out", 24'hA71, {command_data_out, 3'h0, command_data_oe});
        chk("strobe", 24'h131, {register_select_lines, 3'h0, cmd_write});
        chk("one_sel", 24'h20, 24'(station_sel));
        @(negedge clk) cpu_io_wr = 1'b0;
        rd(16'hFCA3, d);
        chk("stn_rd", 24'hA3, 24'(d));
        $display("station test done");
    endtask
    task automatic t_regs();
        {attention_request, host_status_in} = {23'h5A1234, 8'h3C};
        repeat (4) @(negedge clk);
        for (int i = 0; i < 3; i++) begin
            rd(CU + 16'(i), d);
            chk("attn", 24'((24'h5A1234 >> (8 * i)) & 24'hFF), 24'(d));
        end
        wr(CU + 16'h3, 8'h05);
        chk("gated", 24'h0, 24'(host_ctrl_out));
        wr(CU + 16'h3, 8'h85);
        chk("ctrl", 24'h85, 24'(host_ctrl_out));
        rd(CU + 16'h4, d);
        chk("status", 24'h3C, 24'(d));
        rd(CU + 16'h1F, d);
        chk("unmapped", 24'h0, 24'(d));
        $display("register test done");
    endtask
    task automatic t_fifo();
        for (int i = 0; i < 5; i++) begin
            wr(CU + 16'hA, 8'(i));
            wr(CU + 16'hA, 8'hB0 + 8'(i));
        end
        for (int i = 0; i < 4; i++) begin
            chk("stat_word", {8'h1, 8'hB0 + 8'(i), 8'(i)}, {7'h0, host_status_valid, host_status});
            @(negedge clk) host_status_ready = 1'b1;
            @(negedge clk) host_status_ready = 1'b0;
        end
        chk("stat_empty", 24'h0, 24'(host_status_valid));
        chk("instr_rdy", 24'h1, 24'(host_instr_ready));
        @(negedge clk) {host_instr, host_instr_valid} = {16'hBE5F, 1'b1};
        @(negedge clk) host_instr_valid = 1'b0;
        rd(CU + 16'hB, d);
        chk("instr_lo", 24'h5F, 24'(d));
        rd(CU + 16'hB, d);
        chk("instr_hi", 24'hBE, 24'(d));
        $display("fifo test done");
    endtask
    task automatic t_mover(input logic dir);
        port_sends = dir;
        wr(CU + 16'h5, 8'h00);
        wr(CU + 16'h6, 8'h01);
        wr(CU + 16'h7, 8'h02);
        wr(CU + 16'h8, 8'h01);
        wr(CU + 16'h9, {7'h0, dir});
        chk("busy", 24'h1, 24'(mover_busy));
        for (n = 0; n < 2000 && mover_busy; n++) @(negedge clk);
        chk("done", 24'h0, 24'(mover_busy));
        if (!dir) begin
            chk("byte0", 24'h3C, 24'(i_host_port_model.rx_mem[0]));
            chk("byte1", 24'h5B, 24'(i_host_port_model.rx_mem[1]));
        end else begin
            chk("word0", 24'hC1C0, 24'(i_host_port_model.wr_mem[0]));
            chk("word2", 24'hC5C4, 24'(i_host_port_model.wr_mem[2]));
        end
        $display("mover test done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        {clk, reset_n, cpu_io_wr, cpu_io_rd, host_instr_valid} = 5'h0;
        {cpu_addr, cpu_data_bits, attention_request} = 47'h0;
        {host_status_in, host_instr, host_status_ready} = 25'h0;
        port_sends = 1'b0;
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        t_select();
        t_station();
        t_regs();
        t_fifo();
        t_mover(1'b0);
        t_mover(1'b1);
        summarize();
    end
endmodule
`default_nettype wire
